//--- verif/amp_host_model.sv
// host program model: bus master issuing commands and fault queries
module amp_host_model
    import amp_fault_pkg::*;
(
    input  wire logic        i_clock,   // system clock
    input  wire logic        i_hready,  // bus ready
    input  wire logic [31:0] i_hrdata,  // read data
    output logic      [31:0] o_haddr,   // address
    output logic      [1:0]  o_htrans,  // transfer type
    output logic             o_hwrite,  // write flag
    output logic      [2:0]  o_hsize,   // transfer size
    output logic      [31:0] o_hwdata,  // write data
    output logic             o_hsel     // slave select
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hung = 1'b0;  // a bounded wait ran out
    // bus idle at time zero
    initial
    begin
        {o_haddr, o_htrans, o_hwrite, o_hsize, o_hwdata, o_hsel} = '0;
    end
    // wait for ready sampled high, bounded
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge i_clock);
        while (i_hready !== 1'b1 && n < 16)
        begin
            @(posedge i_clock);
            n++;
        end
        if (i_hready !== 1'b1) hung = 1'b1;
    endtask
    // one single word transfer, address then data phase
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge i_clock);
        o_haddr  <= {24'h000000, a};
        o_htrans <= 2'h2;
        o_hwrite <= wr;
        o_hsize  <= 3'h2;
        o_hsel   <= 1'b1;
        wait_rdy();
        o_htrans <= 2'h0;
        o_hwdata <= d;
        wait_rdy();
        q = i_hrdata;
    endtask
    // off-on-error on every axis, phasing, handler in thread zero
    task automatic setup;
        logic [31:0] q;
        xfer(1'b1, OFS_CTRL, 32'h000003FF, q);
    endtask
    // lockout recovery: disable, wait, enable
    task automatic recover;
        logic [31:0] q;
        xfer(1'b1, OFS_CMD, 32'h00000001, q);
        repeat (WAIT_CYC + 2) @(posedge i_clock);
        xfer(1'b1, OFS_CMD, 32'h00000002, q);
    endtask
endmodule // amp_host_model

//--- verif/tb_amp_fault_supervisor.sv
// testbench of the amplifier fault supervisor
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, a, b); end end
module tb_amp_fault_supervisor;
    import amp_fault_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, hwrite, hsel, hready, hresp, handler, irq;  // control wires
    sense_t      sense;                    // comparator levels
    logic [11:0] hall;                     // hall pins
    logic [31:0] haddr, hwdata, hrdata, q; // bus words
    logic [1:0]  htrans;                   // transfer type
    logic [2:0]  hsize;                    // transfer size
    logic [3:0]  amp_en;                   // axis enables
    logic [7:0]  r, r2;                    // query results
    int          miscompares = 0, n_compared = 0, n_hdl = 0, h0; // counters
    amp_fault_supervisor u_dut (.i_clock(clk), .i_rst(rst), .i_sense(sense), .i_hall(hall),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hsel(hsel), .i_hready(hready), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp), .o_amp_en(amp_en), .o_handler(handler),
        .o_irq(irq));
    amp_host_model u_host (.i_clock(clk), .i_hready(hready), .i_hrdata(hrdata),
        .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
        .o_hwdata(hwdata), .o_hsel(hsel));
    // 50 ns clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // count handler dispatch pulses
    always @(posedge clk) if (handler === 1'b1) n_hdl <= n_hdl + 1;
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, q);
    endtask
    task automatic qry(input logic [1:0] i, output logic [7:0] v);
        wr(OFS_QUERY, {30'h0, i});
        u_host.xfer(1'b0, OFS_RESULT, 32'h0, q);
        v = q[7:0];
    endtask
    // let synchroniser and enable logic settle, then check enables
    task automatic chk_en(input logic [3:0] e);
        repeat (5) @(posedge clk);
        `CHK(amp_en, e)
    endtask
    task automatic t_lockout;
        h0 = n_hdl;
        sense.lockout <= 1'b1;
        chk_en(4'h0);
        `CHK(n_hdl > h0, 1'b1)
        `CHK(irq, 1'b1)
        qry(2'h3, r);
        `CHK(r != 8'h00, 1'b1)
        h0 = n_hdl;
        qry(2'h3, r2);
        `CHK(r2, r)
        `CHK(n_hdl, h0)
        sense.lockout <= 1'b0;
        wr(OFS_CMD, 32'h2);
        chk_en(4'h0);
        u_host.recover();
        chk_en(4'hF);
        wr(OFS_IRQ_STAT, 32'h3F);
        chk_en(4'hF);
        `CHK(irq, 1'b0)
    endtask
    task automatic t_hall;
        h0 = n_hdl;
        hall <= 12'h278;
        chk_en(4'hC);
        `CHK(n_hdl > h0, 1'b1)
        qry(2'h1, r);
        `CHK(r[1:0], 2'h3)
        hall <= 12'h249;
        wr(OFS_CMD, 32'h2);
        chk_en(4'hF);
    endtask
    task automatic t_supply;
        sense.under_v <= 1'b1;
        chk_en(4'h0);
        qry(2'h0, r);
        `CHK(r[F_UNDER_V], 1'b1)
        sense.under_v <= 1'b0;
        chk_en(4'hF);
        h0 = n_hdl;
        sense.over_v_hi <= 1'b1;
        sense.over_v_lo <= 1'b1;
        chk_en(4'h0);
        sense.over_v_hi <= 1'b0;
        chk_en(4'h0);
        sense.over_v_lo <= 1'b0;
        chk_en(4'hF);
        `CHK(n_hdl, h0)
        sense.cont_lim <= 4'h5;
        chk_en(4'hF);
        qry(2'h2, r);
        `CHK(r, 8'h05)
        sense.cont_lim <= 4'h0;
    endtask
    task automatic t_over_i_t;
        wr(OFS_CTRL, 32'h0F0);
        sense.over_i <= 2'h1;
        chk_en(4'h0);
        `CHK(amp_en[1:0], 2'h0)
        sense.over_i <= 2'h0;
        repeat (5) @(posedge clk);
        `CHK(amp_en[1:0], 2'h0)
        wr(OFS_CMD, 32'h2);
        chk_en(4'hF);
        wr(OFS_CTRL, 32'h3FF);
        h0 = n_hdl;
        sense.over_t <= 1'b1;
        chk_en(4'h0);
        `CHK(n_hdl > h0, 1'b1)
        wr(OFS_CMD, 32'h2);
        chk_en(4'h0);
        sense.over_t <= 1'b0;
        chk_en(4'h0);
        wr(OFS_CMD, 32'h2);
        chk_en(4'hF);
    endtask
    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // hang watchdog
    initial
    begin
        repeat (100000) @(posedge clk);
        miscompares++;
        stop_test();
    end
    // main sequence: power up with supply low, then each fault in turn
    initial
    begin
        rst = 1'b1;
        sense = '0;
        sense.under_v = 1'b1;
        hall = 12'h249;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        u_host.xfer(1'b0, OFS_IRQ_STAT, 32'h0, q);
        `CHK(q[EV_UNDER_V], 1'b1)
        u_host.xfer(1'b0, OFS_IRQ_MASK, 32'h0, q);
        `CHK(q[5:0], MASK_RST)
        wr(8'h1C, 32'hFFFFFFFF);
        u_host.xfer(1'b0, 8'h1C, 32'h0, q);
        `CHK(q, 32'h0)
        sense.under_v <= 1'b0;
        u_host.setup();
        wr(OFS_IRQ_MASK, 32'h3F);
        wr(OFS_IRQ_STAT, 32'h3F);
        wr(OFS_CMD, 32'h2);
        chk_en(4'hF);
        t_lockout();
        t_hall();
        t_supply();
        t_over_i_t();
        `CHK(u_host.hung, 1'b0)
        stop_test();
    end
endmodule // tb_amp_fault_supervisor

//--- verilog/amp_fault_pkg.sv
// package: register map, field layouts and types of the amplifier fault supervisor
package amp_fault_pkg;
    localparam int          NUM_AXES      = 4;                   // axes served by one amplifier
    localparam int          NUM_PAIRS     = 2;                   // axis pairs sharing a current sense
    // register byte offsets
    localparam logic [7:0]  OFS_CTRL      = 8'h00;               // control bits
    localparam logic [7:0]  OFS_CMD       = 8'h04;               // command strobes
    localparam logic [7:0]  OFS_QUERY     = 8'h08;               // query index select
    localparam logic [7:0]  OFS_RESULT    = 8'h0C;               // query result, read only
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h10;               // sticky events, write one to clear
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h14;               // event enables
    localparam logic [7:0]  OFS_STATE     = 8'h18;               // live amplifier state
    // control bit positions
    localparam int          CTRL_OE_LSB   = 0;                   // off-on-error per axis, 4 bits
    localparam int          CTRL_P120_LSB = 4;                   // 120 degree phasing per axis
    localparam int          CTRL_HANDLER  = 8;                   // handler label present
    localparam int          CTRL_THREAD0  = 9;                   // thread zero running
    // command bit positions
    localparam int          CMD_DISABLE   = 0;                   // drive disable command
    localparam int          CMD_ENABLE    = 1;                   // axis enable command
    localparam int          CMD_RESET     = 2;                   // controller reset command
    // fault bit positions in query index 0
    localparam int          F_UNDER_V     = 0;                   // supply under-voltage
    localparam int          F_OVER_V      = 1;                   // supply over-voltage
    localparam int          F_OVER_I      = 2;                   // over-current latched
    localparam int          F_OVER_T      = 3;                   // over-temperature latched
    // event bit positions in the interrupt status
    localparam int          EV_LOCKOUT    = 0;                   // lockout asserted
    localparam int          EV_HALL       = 1;                   // hall error appeared
    localparam int          EV_UNDER_V    = 2;                   // under-voltage appeared
    localparam int          EV_OVER_I     = 3;                   // over-current trip
    localparam int          EV_OVER_T     = 4;                   // over-temperature trip
    localparam int          EV_HANDLER    = 5;                   // handler dispatched
    localparam int          EV_W          = 6;                   // event count
    // reset values
    localparam logic [9:0]  CTRL_RST      = 10'h000;             // control after reset
    localparam logic [5:0]  MASK_RST      = 6'h00;               // all events masked
    // recovery wait after drive disable, in ms, counted in clocks
    localparam int          CLK_HZ        = 20_000_000;          // system clock rate
    localparam int          WAIT_MS       = 2;                   // wait between disable and enable
    localparam int          WAIT_CYC      = WAIT_MS * (CLK_HZ / 1000); // least wait in cycles

    // comparator inputs that travel together
    typedef struct packed {
        logic                 lockout;    // emergency lockout input
        logic                 under_v;    // supply below 18 V
        logic                 over_v_hi;  // supply above 94 V
        logic                 over_v_lo;  // supply above 90 V
        logic [NUM_PAIRS-1:0] over_i;     // pair current above 40 A
        logic                 over_t;     // heat sink above 80 C
        logic [NUM_AXES-1:0]  cont_lim;   // current over continuous limit
    } sense_t;

    // query index values
    typedef enum logic [1:0] {
        Q_SUPPLY  = 2'b00,                // supply and thermal faults
        Q_HALL    = 2'b01,                // per-axis hall errors
        Q_CONT    = 2'b10,                // continuous limit exceeded
        Q_LOCKOUT = 2'b11                 // lockout state
    } query_t;

    // lockout recovery sequence
    typedef enum logic [1:0] {
        LK_IDLE   = 2'b00,                // no lockout pending
        LK_LOCKED = 2'b01,                // waiting for drive disable
        LK_WAIT   = 2'b10,                // timing the recovery wait
        LK_READY  = 2'b11                 // enable now clears lockout
    } lock_state_t;
endpackage

//--- verilog/amp_fault_supervisor.sv
// amplifier fault supervisor with an AHB-Lite register slave
//
// How it works
// [RULE1] lockout disables amplifier stage in hardware
// [RULE2] lockout sets query 3 and dispatches handler
// [RULE3] host recovers: disable, wait 2, enable
// [RULE4] host should set off-on-error on all axes
// [RULE5] hall 000 or 111 at 120 phasing errors
// [RULE6] query index 0..3 returns eight bits
// [RULE7] index 0 supply, 1 hall, 2 continuous
// [RULE8] fault in thread zero with handler jumps
// [RULE9] reading the query has no side effect
// [RULE10] hall error disables if off-on-error; handler
// [RULE11] under-voltage disables, recovers automatically
// [RULE12] under-voltage at power up triggers handler; code only sets the event, as reset clears CTRL_HANDLER and CTRL_THREAD0
// [RULE13] over-voltage disables above 94, resumes below 90
// [RULE14] over-voltage never latches nor calls handler
// [RULE15] over-current latches until clear and enable
// [RULE16] over-current shutdown is unconditional
// [RULE17] over-temperature disables and calls handler
// [RULE18] over-temperature latched until cool and enable
// [RULE19] comparator inputs synchronised before use
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
module amp_fault_supervisor
    import amp_fault_pkg::*;
(
    input  wire logic                  i_clock,      // 20 MHz system clock
    input  wire logic                  i_rst,        // synchronous reset, high
    input  wire amp_fault_pkg::sense_t i_sense,      // asynchronous comparator inputs
    input  wire logic [11:0]           i_hall,       // hall inputs, three per axis
    input  wire logic [31:0]           i_haddr,      // bus address
    input  wire logic [1:0]            i_htrans,     // bus transfer type
    input  wire logic                  i_hwrite,     // bus write
    input  wire logic [2:0]            i_hsize,      // bus size
    input  wire logic [31:0]           i_hwdata,     // bus write data
    input  wire logic                  i_hsel,       // slave select
    input  wire logic                  i_hready,     // bus ready in
    output logic      [31:0]           o_hrdata,     // bus read data
    output logic                       o_hreadyout,  // slave ready
    output logic                       o_hresp,      // always okay
    output logic      [3:0]            o_amp_en,     // per-axis amplifier enable
    output logic                       o_handler,    // handler dispatch pulse
    output logic                       o_irq         // level interrupt
);
    import amp_fault_pkg::*;

    // two-stage synchronisers for comparators and hall pins
    sense_t               sense_s1_q;        // first stage, read only by second
    sense_t               sense_q;           // synchronised faults
    logic [11:0]          hall_s1_q;         // first stage of hall pins
    logic [11:0]          hall_q;            // synchronised hall pins

    // always_ff: synchroniser chain
    always_ff @(posedge i_clock)
    begin
        sense_s1_q <= i_sense;               // [RULE19]
        sense_q    <= sense_s1_q;            // [RULE19]
        hall_s1_q  <= i_hall;
        hall_q     <= hall_s1_q;
    end

    // bus address phase capture
    logic                 wr_pend_q;         // write data phase pending
    logic [7:0]           addr_q;            // captured offset
    logic [9:0]           ctrl_q;            // control register
    logic [1:0]           query_q;           // query index
    logic [EV_W-1:0]      stat_q;            // sticky events
    logic [EV_W-1:0]      mask_q;            // event mask
    logic [31:0]          rdata_q;           // read data register
    wire                  access  = i_hsel & i_hready & i_htrans[1];
    wire                  do_wr   = wr_pend_q;
    wire                  wr_ctrl = do_wr & (addr_q == OFS_CTRL);
    wire                  wr_cmd  = do_wr & (addr_q == OFS_CMD);
    wire                  wr_qry  = do_wr & (addr_q == OFS_QUERY);
    wire                  wr_stat = do_wr & (addr_q == OFS_IRQ_STAT);
    wire                  wr_mask = do_wr & (addr_q == OFS_IRQ_MASK);
    wire                  cmd_dis = wr_cmd & i_hwdata[CMD_DISABLE];
    wire                  cmd_en  = wr_cmd & i_hwdata[CMD_ENABLE];
    wire                  cmd_rst = wr_cmd & i_hwdata[CMD_RESET];

    // hall decode: 000 or 111 illegal only with 120 degree phasing
    function automatic logic hall_bad(input logic [2:0] h);
        hall_bad = (h == 3'h0) | (h == 3'h7);
    endfunction

    logic [3:0]           hall_err;          // per-axis hall error
    always_comb
    begin
        for (int a = 0; a < NUM_AXES; a++)
            hall_err[a] = ctrl_q[CTRL_P120_LSB+a] & hall_bad(hall_q[3*a +: 3]); // [RULE5]
    end

    // fault state
    logic                 ov_q;              // over-voltage with hysteresis
    logic                 oi_q;              // over-current latch
    logic                 ot_q;              // over-temperature latch
    logic [3:0]           hall_off_q;        // axes off from hall error
    logic                 uv_prev_q;         // under-voltage last cycle
    logic                 lk_prev_q;         // lockout last cycle
    logic [3:0]           hall_prev_q;       // hall errors last cycle
    lock_state_t          lk_q;              // lockout recovery state
    logic [16:0]          wait_q;            // recovery wait counter
    wire                  oi_any  = |sense_q.over_i;
    wire                  uv      = sense_q.under_v;
    wire                  lock_on = sense_q.lockout | (lk_q != LK_IDLE);
    wire                  uv_rise = uv & ~uv_prev_q;
    wire                  lk_rise = sense_q.lockout & ~lk_prev_q;
    wire                  hl_rise = |(hall_err & ~hall_prev_q);
    wire                  oi_trip = oi_any & ~oi_q;
    wire                  ot_trip = sense_q.over_t & ~ot_q;
    wire                  restart = cmd_en | cmd_rst;
    // handler needs label and a thread zero program; over-voltage never calls it
    wire                  run_hdl = ctrl_q[CTRL_HANDLER] & ctrl_q[CTRL_THREAD0];   // [RULE8]
    wire                  hdl_ev  = run_hdl & (lk_rise | hl_rise | uv_rise | ot_trip); // [RULE14]
    wire                  global_off = lock_on | uv | ov_q | oi_q | ot_q;

    // always_ff: over-voltage hysteresis and fault latches
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            ov_q        <= 1'b0;
            oi_q        <= 1'b0;
            ot_q        <= 1'b0;
            hall_off_q  <= 4'h0;
            uv_prev_q   <= 1'b0;             // power-up under-voltage counts as an edge
            lk_prev_q   <= 1'b0;
            hall_prev_q <= 4'h0;
        end
        else
        begin
            // set above 94 V, clear below 90 V; never latched
            if (sense_q.over_v_hi)
                ov_q <= 1'b1;                // [RULE13]
            else if (!sense_q.over_v_lo)
                ov_q <= 1'b0;                // [RULE13] [RULE14]
            // over-current latch, no setting gates it
            if (oi_any)
                oi_q <= 1'b1;                // [RULE15] [RULE16]
            else if (restart)
                oi_q <= 1'b0;                // [RULE15]
            // over-temperature latch
            if (sense_q.over_t)
                ot_q <= 1'b1;                // [RULE17]
            else if (restart)
                ot_q <= 1'b0;                // [RULE18]
            // hall disable needs off-on-error; enable clears once healthy
            for (int a = 0; a < NUM_AXES; a++)
            begin
                if (hall_err[a] & ctrl_q[CTRL_OE_LSB+a])
                    hall_off_q[a] <= 1'b1;   // [RULE10]
                else if (restart)
                    hall_off_q[a] <= 1'b0;
            end
            uv_prev_q   <= uv;               // [RULE12]
            lk_prev_q   <= sense_q.lockout;
            hall_prev_q <= hall_err;
        end
    end

    // always_ff: lockout recovery sequence
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            lk_q   <= LK_IDLE;
            wait_q <= 17'h00000;
        end
        else if (cmd_rst)
        begin
            lk_q   <= sense_q.lockout ? LK_LOCKED : LK_IDLE;
            wait_q <= 17'h00000;
        end
        else
        begin
            case (lk_q)
                LK_IDLE:
                    if (sense_q.lockout)
                        lk_q <= LK_LOCKED;   // [RULE1]
                LK_LOCKED:
                    if (cmd_dis & ~sense_q.lockout)
                    begin
                        lk_q   <= LK_WAIT;   // [RULE3]
                        wait_q <= 17'h00000;
                    end
                LK_WAIT:
                    if (sense_q.lockout)
                        lk_q <= LK_LOCKED;
                    else if (wait_q == 17'(WAIT_CYC - 1))
                        lk_q <= LK_READY;    // [RULE3]
                    else
                        wait_q <= wait_q + 17'h00001;
                LK_READY:
                    if (sense_q.lockout)
                        lk_q <= LK_LOCKED;
                    else if (cmd_en)
                        lk_q <= LK_IDLE;     // [RULE3]
                default:
                    lk_q <= LK_IDLE;
            endcase
        end
    end

    // query result selection, pure read
    wire [7:0]  q_sup  = {4'h0, ot_q, oi_q, ov_q, uv};
    wire [7:0]  q_res  = (query_q == Q_SUPPLY) ? q_sup :             // [RULE7]
                         (query_q == Q_HALL)   ? {4'h0, hall_err} :  // [RULE7]
                         (query_q == Q_CONT)   ? {4'h0, sense_q.cont_lim} : // [RULE7]
                                                 {7'h00, lock_on};   // [RULE2]
    wire [EV_W-1:0] ev = {hdl_ev, ot_trip, oi_trip, uv_rise, hl_rise, lk_rise};
    wire [31:0] rd_mux = (i_haddr[7:0] == OFS_CTRL)     ? {22'h0, ctrl_q} :
                         (i_haddr[7:0] == OFS_QUERY)    ? {30'h0, query_q} :
                         (i_haddr[7:0] == OFS_RESULT)   ? {24'h0, q_res} :   // [RULE6]
                         (i_haddr[7:0] == OFS_IRQ_STAT) ? {26'h0, stat_q} :
                         (i_haddr[7:0] == OFS_IRQ_MASK) ? {26'h0, mask_q} :
                         (i_haddr[7:0] == OFS_STATE)    ? {24'h0, o_amp_en, 3'h0,
                                                           global_off} :
                                                          32'h0000_0000;

    // always_ff: bus slave and registers
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            wr_pend_q <= 1'b0;
            addr_q    <= 8'h00;
            ctrl_q    <= CTRL_RST;
            query_q   <= 2'b00;
            stat_q    <= '0;
            mask_q    <= MASK_RST;
            rdata_q   <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_q <= access & i_hwrite;
            addr_q    <= i_haddr[7:0];
            // reads load data only; nothing else changes
            if (access & ~i_hwrite)
                rdata_q <= rd_mux;           // [RULE9]
            if (wr_ctrl)
                ctrl_q <= i_hwdata[9:0];
            if (wr_qry)
                query_q <= i_hwdata[1:0];    // [RULE6]
            if (wr_mask)
                mask_q <= i_hwdata[EV_W-1:0];
            // new events win over a write-one clear
            stat_q <= (stat_q & ~(wr_stat ? i_hwdata[EV_W-1:0] : '0)) | ev;
        end
    end

    // always_ff: registered outputs
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_amp_en  <= 4'h0;
            o_handler <= 1'b0;
            o_irq     <= 1'b0;
        end
        else
        begin
            o_amp_en  <= ~({4{global_off}} | hall_off_q); // [RULE1] [RULE11] [RULE16]
            o_handler <= hdl_ev;             // [RULE2] [RULE8] [RULE12] [RULE17]
            o_irq     <= |(stat_q & mask_q);
        end
    end

    assign o_hrdata    = rdata_q;
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

    // checks
    a_lockout_disable: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE1]
        sense_q.lockout |=> (o_amp_en == 4'h0))
        else $error("lockout did not disable amplifier");
    a_overcur_latch: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE15]
        (oi_q & ~restart) |=> oi_q)
        else $error("over-current latch dropped without enable");
    a_overcur_any: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE16]
        oi_any |-> ##3 (o_amp_en == 4'h0))
        else $error("over-current did not disable");
    a_ov_no_handler: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE14]
        (sense_q.over_v_hi & ~(lk_rise | hl_rise | uv_rise | ot_trip)) |=> ~o_handler)
        else $error("over-voltage dispatched the handler");
    a_undervolt_off: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE11]
        uv |=> (o_amp_en == 4'h0))
        else $error("under-voltage did not disable");
    a_overtemp_hold: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE18]
        (ot_q & ~restart) |=> ot_q)
        else $error("over-temperature latch dropped");
    a_query_lockout: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE2]
        (query_q == Q_LOCKOUT & sense_q.lockout) |-> q_res[0])
        else $error("query 3 missed lockout");
    a_hall_detect: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE5]
        (ctrl_q[CTRL_P120_LSB+1] & hall_q[5:3] == 3'h7) |-> hall_err[1])
        else $error("hall 111 not flagged");
    a_read_clean: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE9]
        (access & ~i_hwrite & ~|ev) |=> ($stable(ctrl_q) & $stable(stat_q)))
        else $error("read changed state");
    c_lockout: cover property (@(posedge i_clock) lk_q == LK_READY ##1 lk_q == LK_IDLE);
    c_overcur: cover property (@(posedge i_clock) oi_trip);
    c_handler: cover property (@(posedge i_clock) o_handler);
endmodule // amp_fault_supervisor
